// file: opa_regs.vh
`ifndef OPA_REGS_VH
`define OPA_REGS_VH
// Access-select codes
`define OPA_SEL_CODE      2'b11
`define OPA_SEL_LOCK      2'b10
`define OPA_SEL_VERSION   2'b01
// Version byte addresses
`define OPA_ADDR_MAKER    8'hfc
`define OPA_ADDR_PART     8'hfd
`define OPA_ADDR_STEP     8'hfe
// Lock bit encodings (1 = unprogrammed)
`define OPA_LOCK_LVL0     2'b11
`define OPA_LOCK_LVL1     2'b10
`define OPA_LOCK_LVL2     2'b01
`define OPA_LOCK_LVL3     2'b00
`define OPA_LOCK_RESET    2'b11
// Erased code byte value
`define OPA_ERASED        8'hff
// Address layout
`define OPA_ADDR_W        13
`define OPA_HI_W          5
// Lock write pulse: 100 us at 10 ns period
`define OPA_LOCK_PULSE_NS 100000
`define OPA_CLK_NS        10
`endif

// file: opa_sync.v
`timescale 1ns/1ps
// Three-stage pin synchroniser; output moves when stages two and three agree
module opa_sync #(
    parameter W = 1
) (
    input  wire         clk,    // System clock
    input  wire         rstn,   // Sync reset, active low
    input  wire [W-1:0] rst_val,// Value held during reset
    input  wire [W-1:0] pin,    // Asynchronous pin
    output reg  [W-1:0] q       // Filtered level
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    // Stage one is read only by stage two
    // Stages restart at the idle level, so no false edge follows reset
    always @(posedge clk) begin
        if (!rstn) begin
            s1_q <= rst_val;
            s2_q <= rst_val;
            s3_q <= rst_val;
            q    <= rst_val;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q <= s3_q;
            end
        end
    end
endmodule // opa_sync

// file: opa_otp_access.v
`timescale 1ns/1ps
`include "opa_regs.vh"
module opa_otp_access #(
    parameter       LARGE_VARIANT  = 1,         // 1: all 13 address bits used
    parameter [7:0] MAKER_CODE     = 8'h5a,     // Arbitrary value
    parameter [7:0] PART_TYPE      = 8'h3c,     // Arbitrary value
    parameter [7:0] STEPPING_CODE  = 8'h10,     // Arbitrary value
    parameter       LOCK_PULSE_CYC = (`OPA_LOCK_PULSE_NS + `OPA_CLK_NS - 1) / `OPA_CLK_NS
) (
    input  wire       clk,                // 100 MHz oscillator clock
    input  wire       rstn,               // Sync reset, active low
    input  wire       write_strobe_n_mode,          // Basic programming mode entered
    input  wire       vpp_high,           // Voltage pin at logic high or above
    input  wire [1:0] access_select,      // Access-select pins
    input  wire       write_strobe_n,     // Write strobe pin, active low
    input  wire       read_strobe_n,      // Read strobe pin, active low
    input  wire       high_address_latch_strobe, // Upper address latch pin
    input  wire [7:0] port2_in,           // Address pins
    input  wire [7:0] port0_in,           // Data pins, input side
    output reg  [7:0] port0_out,          // Data pins, output side
    output reg        port0_oe,           // Data pins drive enable
    input  wire       special_map_select, // Map-select bit, normal run
    input  wire [7:0] sfr_addr,           // Normal-run special register address
    output reg  [7:0] sfr_rdata,          // Normal-run version read data
    output reg        sfr_hit,            // Address hits a version byte
    input  wire       ext_access_pin,     // Access pin level at normal run
    input  wire       chip_reset,         // Normal-run reset pulse
    output reg  [1:0] active_level,       // Protection level in force
    output reg        ext_pin_latched_q,  // Latched access pin, level 1+
    output reg        block_ext_table_rd, // Block external table reads
    output reg        block_verify_rd,    // Block verification reads
    output reg        block_ext_exec_pin, // Block pin-started external run
    output reg        write_strobe_n_entry_refused  // Programming mode re-entry refused
);
    localparam CW = 17;
    localparam AW = `OPA_ADDR_W;
    localparam [1:0] ST_IDLE  = 2'b00;
    localparam [1:0] ST_WRITE = 2'b01;
    localparam [1:0] ST_DONE  = 2'b10;

    // Code memory and lock state
    reg [7:0]      mem [0:(1<<AW)-1];
    reg [1:0]      lock_bits_q;
    reg [1:0]      lock_bits_d;
    reg [`OPA_HI_W-1:0] hi_addr_q;
    reg            code_armed_q;
    reg [1:0]      latched_sel_q;
    reg [1:0]      wr_state_q;
    reg [CW-1:0]   pulse_cnt_q;
    reg            write_strobe_n_mode_q;
    reg [7:0]      rd_data_d;
    reg            rd_drive_d;
    integer        i;

    // Synchronised pin levels
    wire [1:0] sel_s;
    wire       wr_n_s;
    wire       rd_n_s;
    wire       ale_s;
    wire [7:0] p2_s;
    wire [7:0] p0_s;
    wire       ea_s;
    reg        ale_prev_q;
    reg        wr_prev_n_q;

    // All programmer pins except mode and voltage pass the three-stage filter
    opa_sync #(.W(22)) u_sync (
        .clk     (clk),
        .rstn    (rstn),
        .rst_val ({2'b00, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00, 1'b1}),
        .pin     ({access_select, write_strobe_n, read_strobe_n,
                   high_address_latch_strobe, port2_in, port0_in, ext_access_pin}),
        .q       ({sel_s, wr_n_s, rd_n_s, ale_s, p2_s, p0_s, ea_s})
    );

    // Accesses are only honoured in programming mode with voltage present
    // access gate
    wire acc_ok   = write_strobe_n_mode && vpp_high && !write_strobe_n_entry_refused;
    wire ale_rise = ale_s && !ale_prev_q;
    wire ale_fall = !ale_s && ale_prev_q;
    wire wr_fall  = !wr_n_s && wr_prev_n_q;

    // Full address; bit 12 dropped on the small variant
    // bit 12 ignored on small variant
    wire [AW-1:0] full_addr = {(LARGE_VARIANT != 0) ? hi_addr_q[4] : 1'b0,
                               hi_addr_q[3:0], p2_s};

    // Protection stays at the old level while in programming mode
    // lock decode
    wire lvl_protected = (lock_bits_q != `OPA_LOCK_LVL0);

    // Edge history of strobes
    always @(posedge clk) begin
        if (!rstn) begin
            ale_prev_q  <= 1'b0;
            wr_prev_n_q <= 1'b1;
        end else begin
            ale_prev_q  <= ale_s;
            wr_prev_n_q <= wr_n_s;
        end
    end

    // Mode arming and paged upper address
    always @(posedge clk) begin
        if (!rstn) begin
            code_armed_q  <= 1'b0;
            latched_sel_q <= 2'b00;
            hi_addr_q     <= {`OPA_HI_W{1'b0}};
        end else if (acc_ok) begin
            if (ale_rise) begin
                code_armed_q  <= (sel_s == `OPA_SEL_CODE);
                latched_sel_q <= sel_s;
            end
            if (ale_fall && latched_sel_q == `OPA_SEL_CODE) begin
                hi_addr_q <= p2_s[`OPA_HI_W-1:0];
            end
            // A different select drops the code arming until relatched
            if (sel_s != `OPA_SEL_CODE) begin
                code_armed_q <= 1'b0;
            end
        end else begin
            code_armed_q <= 1'b0;
        end
    end

    // Write handling: one program operation per strobe low phase
    // write strobe timing
    always @(posedge clk) begin
        if (!rstn) begin
            wr_state_q  <= ST_IDLE;
            pulse_cnt_q <= {CW{1'b0}};
            lock_bits_q <= `OPA_LOCK_RESET;
            for (i = 0; i < (1<<AW); i = i + 1) begin
                mem[i] <= `OPA_ERASED;
            end
        end else begin
            case (wr_state_q)
                ST_IDLE: begin
                    pulse_cnt_q <= {CW{1'b0}};
                    if (acc_ok && wr_fall) begin
                        wr_state_q <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (wr_n_s) begin
                        wr_state_q <= ST_IDLE;
                    end else begin
                        pulse_cnt_q <= pulse_cnt_q + {{(CW-1){1'b0}}, 1'b1};
                        // new lock bits wait for mode exit
                        if (sel_s == `OPA_SEL_CODE && code_armed_q && active_level == 2'b00) begin
                            mem[full_addr] <= mem[full_addr] & p0_s;
                            wr_state_q     <= ST_DONE;
                        end else if (sel_s == `OPA_SEL_LOCK) begin
                            if (pulse_cnt_q >= LOCK_PULSE_CYC[CW-1:0] - 1'b1) begin
                                lock_bits_q <= lock_bits_d;
                                wr_state_q  <= ST_DONE;
                            end
                        end else begin
                            wr_state_q <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    if (wr_n_s) begin
                        wr_state_q <= ST_IDLE;
                    end
                end
                default: wr_state_q <= ST_IDLE;
            endcase
        end
    end

    // Programming clears lock bits only; unprogrammed bits stay
    always @* begin
        lock_bits_d = lock_bits_q & p0_s[1:0];
    end

    // Read data selection
    // data over port 0
    always @* begin
        rd_data_d  = 8'h00;
        rd_drive_d = 1'b0;
        if (acc_ok && !rd_n_s && wr_n_s) begin
            case (sel_s)
                `OPA_SEL_CODE: begin
                    rd_drive_d = code_armed_q;
                    rd_data_d  = mem[full_addr];
                end
                `OPA_SEL_LOCK: begin
                    rd_drive_d = 1'b1;
                    rd_data_d  = {6'h3f, lock_bits_q};
                end
                `OPA_SEL_VERSION: begin
                    rd_drive_d = 1'b1;
                    case (p2_s)
                        `OPA_ADDR_MAKER: rd_data_d = MAKER_CODE;
                        `OPA_ADDR_PART:  rd_data_d = PART_TYPE;
                        `OPA_ADDR_STEP:  rd_data_d = STEPPING_CODE;
                        default:         rd_data_d = 8'h00;
                    endcase
                end
                default: rd_drive_d = 1'b0;
            endcase
        end
    end

    // Port 0 driver, registered
    // drive only on read
    always @(posedge clk) begin
        if (!rstn) begin
            port0_out <= 8'h00;
            port0_oe  <= 1'b0;
        end else begin
            port0_out <= rd_data_d;
            port0_oe  <= rd_drive_d;
        end
    end

    // Normal-run version byte window
    // mapped read
    always @(posedge clk) begin
        if (!rstn) begin
            sfr_rdata <= 8'h00;
            sfr_hit   <= 1'b0;
        end else begin
            sfr_hit   <= 1'b0;
            sfr_rdata <= 8'h00;
            if (special_map_select && !write_strobe_n_mode) begin
                case (sfr_addr)
                    `OPA_ADDR_MAKER: begin
                        sfr_rdata <= MAKER_CODE;
                        sfr_hit   <= 1'b1;
                    end
                    `OPA_ADDR_PART: begin
                        sfr_rdata <= PART_TYPE;
                        sfr_hit   <= 1'b1;
                    end
                    `OPA_ADDR_STEP: begin
                        sfr_rdata <= STEPPING_CODE;
                        sfr_hit   <= 1'b1;
                    end
                    default: sfr_hit <= 1'b0;
                endcase
            end
        end
    end

    // Protection takes hold on leaving programming mode
    // activate on exit
    always @(posedge clk) begin
        if (!rstn) begin
            write_strobe_n_mode_q        <= 1'b0;
            active_level       <= 2'b00;
            write_strobe_n_entry_refused <= 1'b0;
        end else begin
            write_strobe_n_mode_q <= write_strobe_n_mode;
            if (write_strobe_n_mode_q && !write_strobe_n_mode) begin
                active_level <= ~lock_bits_q;
                write_strobe_n_entry_refused <= lvl_protected;
            end
        end
    end

    // Restrictions derived from the level in force
    // level 0 free
    always @(posedge clk) begin
        if (!rstn) begin
            block_ext_table_rd <= 1'b0;
            block_verify_rd    <= 1'b0;
            block_ext_exec_pin <= 1'b0;
            ext_pin_latched_q  <= 1'b1;
        end else begin
            block_ext_table_rd <= (active_level != 2'b00);
            block_verify_rd    <= (active_level >= 2'b10);
            block_ext_exec_pin <= (active_level == 2'b11);
            if (chip_reset && active_level != 2'b00) begin
                ext_pin_latched_q <= ea_s;
            end else if (active_level == 2'b00) begin
                ext_pin_latched_q <= ea_s;
            end
        end
    end
endmodule // opa_otp_access

// file: opa_otp_access_properties.sv
`timescale 1ns/1ps
// Port-level checks of the programming interface
module opa_otp_access_properties #(
    parameter [7:0] MAKER_CODE = 8'h5a // Arbitrary value
) (
    input wire       clk,                // Clock
    input wire       rstn,               // Sync reset, active low
    input wire       write_strobe_n_mode,          // Mode entered
    input wire       read_strobe_n,      // Read strobe
    input wire       write_strobe_n,     // Write strobe
    input wire       port0_oe,           // Data drive enable
    input wire [1:0] active_level,       // Level in force
    input wire       block_ext_table_rd, // Table reads blocked
    input wire       block_verify_rd,    // Verify reads blocked
    input wire       block_ext_exec_pin, // Pin-started run blocked
    input wire       write_strobe_n_entry_refused, // Re-entry refused
    input wire       special_map_select, // Map-select bit
    input wire [7:0] sfr_addr,           // Normal-run address
    input wire [7:0] sfr_rdata,          // Normal-run data
    input wire       sfr_hit             // Version byte hit
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // Flags may trail a level change by one cycle, hence two cycles of level
    oe_idle_read_a: assert property (read_strobe_n [*8] |-> !port0_oe)
        else $error("data pins driven with read strobe high");
    oe_no_mode_a: assert property (!write_strobe_n_mode [*8] |-> !port0_oe)
        else $error("data pins driven outside programming mode");
    level_frozen_a: assert property (write_strobe_n_mode && $past(write_strobe_n_mode) |-> $stable(active_level))
        else $error("protection changed inside programming mode");
    level_open_a: assert property ((active_level == 2'd0) [*2] |->
        !(block_ext_table_rd || block_verify_rd || block_ext_exec_pin || write_strobe_n_entry_refused))
        else $error("restriction active at level 0");
    level_one_a: assert property ((active_level == 2'd1) [*2] |->
        block_ext_table_rd && !block_verify_rd && !block_ext_exec_pin && write_strobe_n_entry_refused)
        else $error("level 1 restrictions wrong");
    level_two_a: assert property ((active_level == 2'd2) [*2] |->
        block_ext_table_rd && block_verify_rd && !block_ext_exec_pin && write_strobe_n_entry_refused)
        else $error("level 2 restrictions wrong");
    level_three_a: assert property ((active_level == 2'd3) [*2] |->
        block_ext_table_rd && block_verify_rd && block_ext_exec_pin && write_strobe_n_entry_refused)
        else $error("level 3 restrictions wrong");
    sfr_map_a: assert property (special_map_select && !write_strobe_n_mode && sfr_addr == 8'hfc |=>
        sfr_hit && sfr_rdata == MAKER_CODE)
        else $error("mapped maker byte not returned");
    sfr_off_a: assert property (!special_map_select |=> !sfr_hit)
        else $error("version hit without map select");
endmodule // opa_otp_access_properties

bind opa_otp_access opa_otp_access_properties #(.MAKER_CODE(MAKER_CODE)) u_props (
    .clk, .rstn, .write_strobe_n_mode, .read_strobe_n, .write_strobe_n, .port0_oe, .active_level,
    .block_ext_table_rd, .block_verify_rd, .block_ext_exec_pin, .write_strobe_n_entry_refused,
    .special_map_select, .sfr_addr, .sfr_rdata, .sfr_hit);

// file: opa_programmer.sv
`timescale 1ns/1ps
// Programmer model: owns the access pins, one request at a time
module opa_programmer (
    input  wire       clk,            // Clock
    input  wire [7:0] port0,          // Data pin level
    input  wire       dev_drives,     // Device drives data
    output reg        write_strobe_n_mode,      // Mode entered
    output reg        vpp_high,       // Voltage pin high
    output reg  [1:0] access_select,  // Mode select
    output reg        write_strobe_n, // Write strobe
    output reg        read_strobe_n,  // Read strobe
    output reg        latch_strobe,   // Upper address latch
    output reg  [7:0] port2,          // Address pins
    output reg  [7:0] data_out,       // Write data
    output reg        data_oe         // Write data enable
);
    // Idle pins at time zero
    initial begin
        {write_strobe_n_mode, vpp_high, access_select, latch_strobe} = 5'h00;
        {write_strobe_n, read_strobe_n} = 2'b11;
        {port2, data_out, data_oe} = 17'h0;
    end
    task automatic mode(input on);
        @(posedge clk);
        write_strobe_n_mode <= on;
        vpp_high  <= on;
        repeat (6) @(posedge clk);
    endtask
    task automatic volt(input on);
        @(posedge clk);
        vpp_high <= on;
        repeat (6) @(posedge clk);
    endtask
    task automatic page(input [4:0] hi);
        @(posedge clk);
        access_select <= 2'b11;
        port2         <= {3'h0, hi};
        latch_strobe  <= 1'b1;
        repeat (6) @(posedge clk);
        latch_strobe <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // Lines move only with strobes high
    task automatic access(input [1:0] sel, input wr, input [7:0] a, input [7:0] d,
                          input integer hold, output [7:0] q, output oe);
        @(posedge clk);
        access_select <= sel;
        port2         <= a;
        data_out      <= d;
        data_oe       <= wr;
        repeat (5) @(posedge clk);
        if (wr) write_strobe_n <= 1'b0;
        else read_strobe_n <= 1'b0;
        repeat (hold) @(posedge clk);
        #1;
        q  = port0;
        oe = dev_drives;
        @(posedge clk);
        write_strobe_n <= 1'b1;
        read_strobe_n  <= 1'b1;
        repeat (8) @(posedge clk);
        data_oe <= 1'b0;
    endtask
endmodule // opa_programmer

// file: opa_otp_access_test.sv
`timescale 1ns/1ps
`include "opa_regs.vh"
// Bench for the programming interface
module opa_otp_access_test;
    localparam [7:0] MK = 8'h5a; // Arbitrary value
    localparam [7:0] PT = 8'h3c; // Arbitrary value
    localparam [7:0] ST = 8'h10; // Arbitrary value
    reg        clk = 1'b0;
    reg        rstn = 1'b0;
    reg        special_map_select = 1'b0;
    reg  [7:0] sfr_addr = 8'h00;
    reg        ext_access_pin = 1'b1;
    reg        chip_reset = 1'b0;
    reg  [7:0] q;
    reg        oe;
    integer    bad_count = 0;
    integer    total_checks = 0;
    integer    lv;
    wire       write_strobe_n_mode, vpp_high, write_strobe_n, read_strobe_n, latch_strobe, data_oe;
    wire       port0_oe, sfr_hit, ext_pin_latched_q, write_strobe_n_entry_refused;
    wire       block_ext_table_rd, block_verify_rd, block_ext_exec_pin;
    wire [1:0] access_select, active_level;
    wire [7:0] port2, data_out, port0_out, port0, sfr_rdata;
    wire [7:0] status = {active_level, ext_pin_latched_q, block_ext_table_rd, block_verify_rd,
                         block_ext_exec_pin, write_strobe_n_entry_refused, port0_oe};

    // Clock inverts each half period
    always #5 clk = ~clk;
    // Released data pins show the inverse of the last write data
    assign port0 = port0_oe ? port0_out : (data_oe ? data_out : ~data_out);

    opa_programmer u_write_strobe_n (.clk, .port0, .dev_drives(port0_oe), .write_strobe_n_mode, .vpp_high,
        .access_select, .write_strobe_n, .read_strobe_n, .latch_strobe, .port2, .data_out, .data_oe);
    opa_otp_access #(.LOCK_PULSE_CYC(20), .MAKER_CODE(MK), .PART_TYPE(PT), .STEPPING_CODE(ST)) u_dut (
        .clk, .rstn, .write_strobe_n_mode, .vpp_high, .access_select, .write_strobe_n, .read_strobe_n,
        .high_address_latch_strobe(latch_strobe), .port2_in(port2), .port0_in(port0), .port0_out,
        .port0_oe, .special_map_select, .sfr_addr, .sfr_rdata, .sfr_hit, .ext_access_pin, .chip_reset,
        .active_level, .ext_pin_latched_q, .block_ext_table_rd, .block_verify_rd, .block_ext_exec_pin,
        .write_strobe_n_entry_refused);

    task check(input [7:0] seen, input [7:0] exp);
        #1;
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Two edges of reset; the pin filters restart at their idle levels
    task rst;
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    // One access; for reads d is the expected byte
    task xfer(input [1:0] sel, input wr, input [7:0] a, input [7:0] d, input integer hold, input exp_oe);
        u_write_strobe_n.access(sel, wr, a, d, hold, q, oe);
        check({7'h0, oe}, {7'h0, exp_oe});
        if (exp_oe) check(q, d);
    endtask

    // Watchdog: far beyond the roughly 1100 cycles needed
    initial begin
        #100000;
        bad_count = bad_count + 1;
        results;
    end

    // Main sequence
    initial begin
        rst;
        check(status, 8'h20);
        u_write_strobe_n.mode(1'b1);
        u_write_strobe_n.volt(1'b0);
        xfer(`OPA_SEL_VERSION, 1'b0, `OPA_ADDR_MAKER, MK, 8, 1'b0);
        u_write_strobe_n.volt(1'b1);
        xfer(`OPA_SEL_VERSION, 1'b0, `OPA_ADDR_MAKER, MK, 8, 1'b1);
        xfer(`OPA_SEL_VERSION, 1'b0, `OPA_ADDR_PART, PT, 8, 1'b1);
        xfer(`OPA_SEL_VERSION, 1'b0, `OPA_ADDR_STEP, ST, 8, 1'b1);
        xfer(`OPA_SEL_VERSION, 1'b0, 8'hff, 8'h00, 8, 1'b1);
        xfer(`OPA_SEL_VERSION, 1'b1, `OPA_ADDR_STEP, 8'h00, 8, 1'b0);
        xfer(`OPA_SEL_VERSION, 1'b0, `OPA_ADDR_STEP, ST, 8, 1'b1);
        $display("test version bytes done");
        // Code access before any latch pulse is refused
        xfer(`OPA_SEL_CODE, 1'b0, 8'h23, 8'hff, 8, 1'b0);
        u_write_strobe_n.page(5'h11);
        xfer(`OPA_SEL_CODE, 1'b1, 8'h23, 8'ha5, 8, 1'b0);
        xfer(`OPA_SEL_CODE, 1'b0, 8'h23, 8'ha5, 8, 1'b1);
        xfer(`OPA_SEL_CODE, 1'b0, 8'h24, 8'hff, 8, 1'b1);
        u_write_strobe_n.page(5'h01);
        xfer(`OPA_SEL_CODE, 1'b0, 8'h23, 8'hff, 8, 1'b1);
        u_write_strobe_n.page(5'h11);
        xfer(`OPA_SEL_CODE, 1'b0, 8'h23, 8'ha5, 8, 1'b1);
        $display("test code bytes done");
        // Protection levels 1 to 3; reset restores unprogrammed lock bits
        for (lv = 1; lv < 4; lv = lv + 1) begin
            rst;
            ext_access_pin <= 1'b1;
            u_write_strobe_n.mode(1'b1);
            xfer(`OPA_SEL_LOCK, 1'b0, 8'h00, 8'hff, 8, 1'b1);
            xfer(`OPA_SEL_LOCK, 1'b1, 8'h00, {6'h3f, ~lv[1:0]}, 24, 1'b0);
            xfer(`OPA_SEL_LOCK, 1'b0, 8'h00, {6'h3f, ~lv[1:0]}, 8, 1'b1);
            check(status, 8'h20);
            u_write_strobe_n.page(5'h00);
            xfer(`OPA_SEL_CODE, 1'b1, 8'h42, 8'h3c, 8, 1'b0);
            xfer(`OPA_SEL_CODE, 1'b0, 8'h42, 8'h3c, 8, 1'b1);
            u_write_strobe_n.mode(1'b0);
            check(status, {lv[1:0], 2'b11, lv[1:0] != 2'd1, lv[1:0] == 2'd3, 2'b10});
            @(posedge clk);
            ext_access_pin <= 1'b0;
            repeat (6) @(posedge clk);
            chip_reset <= 1'b1;
            repeat (4) @(posedge clk);
            chip_reset <= 1'b0;
            repeat (6) @(posedge clk);
            check({7'h0, ext_pin_latched_q}, 8'h00);
            u_write_strobe_n.mode(1'b1);
            xfer(`OPA_SEL_LOCK, 1'b0, 8'h00, 8'hff, 8, 1'b0);
            u_write_strobe_n.mode(1'b0);
        end
        $display("test protection levels done");
        // Version byte through the special map in normal run
        @(posedge clk);
        special_map_select <= 1'b1;
        sfr_addr           <= `OPA_ADDR_MAKER;
        repeat (2) @(posedge clk);
        check(sfr_rdata, MK);
        @(posedge clk);
        sfr_addr <= `OPA_ADDR_PART;
        repeat (2) @(posedge clk);
        check(sfr_rdata, PT);
        @(posedge clk);
        sfr_addr <= `OPA_ADDR_STEP;
        repeat (2) @(posedge clk);
        check(sfr_rdata, ST);
        check({7'h0, sfr_hit}, 8'h01);
        // Mapped window is closed while programming mode is active
        u_write_strobe_n.mode(1'b1);
        check({7'h0, sfr_hit}, 8'h00);
        u_write_strobe_n.mode(1'b0);
        @(posedge clk);
        special_map_select <= 1'b0;
        repeat (2) @(posedge clk);
        check({7'h0, sfr_hit}, 8'h00);
        $display("test mapped read done");
        results;
    end
endmodule // opa_otp_access_test
